// ### lcdsd_regs.svh
// Constants of the segment LCD driver: sizes, field positions, reset values, drive levels
`ifndef LCDSD_REGS_SVH
`define LCDSD_REGS_SVH

// ----------------------------------------------------------------
// Panel geometry and pointer layout
// ----------------------------------------------------------------
`define LCDSD_SEG_COUNT        32
`define LCDSD_COM_COUNT        4
`define LCDSD_PTR_WIDTH        6
`define LCDSD_PTR_LOW_MSB      3
`define LCDSD_PTR_HIGH_MSB     5
`define LCDSD_PTR_HIGH_LSB     4
`define LCDSD_PTR_RESET        6'h00
`define LCDSD_RAM_RESET        4'h0

// ----------------------------------------------------------------
// Alternating-frequency divider: base divide by 64 shifted by select
// ----------------------------------------------------------------
`define LCDSD_DIV_BASE         10'h040
`define LCDSD_DIV_WIDTH        10
`define LCDSD_DIV_RESET        10'h000

// ----------------------------------------------------------------
// Drive level codes, 1/3 bias steps (0 = VSS, 3 = full LCD supply)
// ----------------------------------------------------------------
`define LCDSD_LEVEL_V0         2'h0
`define LCDSD_LEVEL_V1         2'h1
`define LCDSD_LEVEL_V2         2'h2
`define LCDSD_LEVEL_V3         2'h3

`endif

// ### lcdsd_pkg.sv
// Types shared by the segment LCD driver and its surroundings
package lcdsd_pkg;

    // ----------------------------------------------------------------
    // Instruction strobes from the CPU core, one cycle each
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       pointer_low_load;
        logic       pointer_high_load;
        logic       ram_write;
        logic       ram_read;
        logic       display_on_command;
        logic       display_off_command;
        logic [3:0] data;
    } lcdsd_cmd_type;

    // Read answer back to data RAM
    typedef struct packed {
        logic       valid;
        logic [3:0] data;
    } lcdsd_rsp_type;

    typedef logic [1:0] lcdsd_level_type;

endpackage

// ### lcdsd_driver.sv
// Segment LCD controller/driver: pattern RAM, pointer, divider and bias waveforms
`timescale 1ns/1ps
`include "lcdsd_regs.svh"

module lcdsd_driver
    import lcdsd_pkg::*;
#(
    parameter int SEGS = `LCDSD_SEG_COUNT,
    parameter int COMS = `LCDSD_COM_COUNT
) (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  slow_clk_pin,
    input  wire logic [1:0]            freq_select,
    input  wire lcdsd_cmd_type         cmd,
    output lcdsd_rsp_type              rsp,
    output lcdsd_level_type [COMS-1:0] com_level,
    output lcdsd_level_type [SEGS-1:0] seg_level,
    output logic                       display_enabled
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [2:0]                       slow_sync;
    logic [2:0]                       next_slow_sync;
    logic [`LCDSD_DIV_WIDTH-1:0]      div_cnt;
    logic [`LCDSD_DIV_WIDTH-1:0]      next_div_cnt;
    logic [1:0]                       phase;
    logic [1:0]                       next_phase;
    logic                             polarity;
    logic                             next_polarity;
    logic                             next_display_enabled;
    logic [`LCDSD_PTR_WIDTH-1:0]      display_ram_pointer;
    logic [`LCDSD_PTR_WIDTH-1:0]      next_pointer;
    logic [3:0]                       panel_pattern_ram [SEGS];
    logic [3:0]                       next_ram [SEGS];
    lcdsd_rsp_type                    next_rsp;
    lcdsd_level_type [COMS-1:0]       next_com_level;
    lcdsd_level_type [SEGS-1:0]       next_seg_level;
    logic                             slow_rise;
    logic                             af_tick;
    logic [`LCDSD_DIV_WIDTH-1:0]      divisor;

    // ----------------------------------------------------------------
    // Slow clock: two flops, then a third for edge detect only
    // ----------------------------------------------------------------
    assign next_slow_sync = {slow_sync[1:0], slow_clk_pin};
    assign slow_rise      = slow_sync[1] & ~slow_sync[2];

    // Divide slow edges down to the alternating frequency
    assign divisor = `LCDSD_DIV_WIDTH'(`LCDSD_DIV_BASE << freq_select);
    assign af_tick = slow_rise && (div_cnt == divisor - `LCDSD_DIV_WIDTH'(1));

    always_comb begin
        next_div_cnt  = div_cnt;
        next_phase    = phase;
        next_polarity = polarity;
        if (slow_rise) begin
            // Select change mid-count: wrap rather than run past the end
            if (div_cnt >= divisor - `LCDSD_DIV_WIDTH'(1)) begin
                next_div_cnt = `LCDSD_DIV_RESET;
            end else begin
                next_div_cnt = div_cnt + `LCDSD_DIV_WIDTH'(1);
            end
        end
        if (af_tick) begin
            next_phase = phase + 2'h1;
            if (phase == 2'h3) begin
                next_polarity = ~polarity;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            slow_sync <= 3'h0;
            div_cnt   <= `LCDSD_DIV_RESET;
            phase     <= 2'h0;
            polarity  <= 1'b0;
        end else begin
            slow_sync <= next_slow_sync;
            div_cnt   <= next_div_cnt;
            phase     <= next_phase;
            polarity  <= next_polarity;
        end
    end

    // ----------------------------------------------------------------
    // Pointer, pattern RAM and display control
    // ----------------------------------------------------------------
    always_comb begin
        next_pointer         = display_ram_pointer;
        next_display_enabled = display_enabled;
        next_rsp             = '{valid: 1'b0, data: 4'h0};
        for (int k = 0; k < SEGS; k++) begin
            next_ram[k] = panel_pattern_ram[k];
        end
        if (cmd.pointer_low_load) begin
            next_pointer[`LCDSD_PTR_LOW_MSB:0] = cmd.data;
        end
        if (cmd.pointer_high_load) begin
            next_pointer[`LCDSD_PTR_HIGH_MSB:`LCDSD_PTR_HIGH_LSB] = cmd.data[1:0];
        end
        // Pointer values past the last nibble hit nothing: writes dropped, reads zero
        if (cmd.ram_write && !display_ram_pointer[5]) begin
            next_ram[display_ram_pointer[4:0]] = cmd.data;
        end
        if (cmd.ram_read) begin
            next_rsp.valid = 1'b1;
            next_rsp.data  = display_ram_pointer[5] ? 4'h0
                           : panel_pattern_ram[display_ram_pointer[4:0]];
        end
        // Off wins if both arrive together
        if (cmd.display_on_command) begin
            next_display_enabled = 1'b1;
        end
        if (cmd.display_off_command) begin
            next_display_enabled = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            display_ram_pointer <= `LCDSD_PTR_RESET;
            display_enabled     <= 1'b0;
            rsp                 <= '{valid: 1'b0, data: 4'h0};
            for (int k = 0; k < SEGS; k++) begin
                panel_pattern_ram[k] <= `LCDSD_RAM_RESET;
            end
        end else begin
            display_ram_pointer <= next_pointer;
            display_enabled     <= next_display_enabled;
            rsp                 <= next_rsp;
            for (int k = 0; k < SEGS; k++) begin
                panel_pattern_ram[k] <= next_ram[k];
            end
        end
    end

    // ----------------------------------------------------------------
    // Bias waveforms; off drives every electrode to VSS, no net field
    // ----------------------------------------------------------------
    always_comb begin
        for (int n = 0; n < COMS; n++) begin
            if (!display_enabled) begin
                next_com_level[n] = `LCDSD_LEVEL_V0;
            end else if (phase == 2'(n)) begin
                next_com_level[n] = polarity ? `LCDSD_LEVEL_V0 : `LCDSD_LEVEL_V3;
            end else begin
                next_com_level[n] = polarity ? `LCDSD_LEVEL_V2 : `LCDSD_LEVEL_V1;
            end
        end
        // Pattern fetched straight from RAM each cycle, no software copy
        for (int k = 0; k < SEGS; k++) begin
            if (!display_enabled) begin
                next_seg_level[k] = `LCDSD_LEVEL_V0;
            end else if (panel_pattern_ram[k][phase]) begin
                next_seg_level[k] = polarity ? `LCDSD_LEVEL_V3 : `LCDSD_LEVEL_V0;
            end else begin
                next_seg_level[k] = polarity ? `LCDSD_LEVEL_V1 : `LCDSD_LEVEL_V2;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            com_level <= '0;
            seg_level <= '0;
        end else begin
            com_level <= next_com_level;
            seg_level <= next_seg_level;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    pointer_low_a: assert property (cmd.pointer_low_load |=>
        display_ram_pointer[3:0] == $past(cmd.data)) else $error("pointer low load lost");
    pointer_high_a: assert property (cmd.pointer_high_load |=>
        display_ram_pointer[5:4] == $past(cmd.data[1:0])) else $error("pointer high load lost");
    ram_write_a: assert property ((cmd.ram_write && !display_ram_pointer[5]) |=>
        panel_pattern_ram[$past(display_ram_pointer[4:0])] == $past(cmd.data))
        else $error("pattern write lost");
    read_back_a: assert property ((cmd.ram_read && !display_ram_pointer[5]) |=>
        rsp.valid && rsp.data == $past(panel_pattern_ram[display_ram_pointer[4:0]]))
        else $error("pattern read wrong");
    display_off_a: assert property (cmd.display_off_command |=>
        !display_enabled ##1 (com_level == '0 && seg_level == '0))
        else $error("display off not honoured");
    divider_range_a: assert property (af_tick |=>
        div_cnt == `LCDSD_DIV_RESET) else $error("divider did not restart after tick");
    frame_flip_a: assert property ((af_tick && phase == 2'h3) |=>
        polarity != $past(polarity) && phase == 2'h0) else $error("frame polarity not flipped");
    common_select_a: assert property (display_enabled |=>
        com_level[$past(phase)] == ($past(polarity) ? `LCDSD_LEVEL_V0 : `LCDSD_LEVEL_V3))
        else $error("selected common level wrong");
    seg_lit_a: assert property ((display_enabled && panel_pattern_ram[0][phase]) |=>
        seg_level[0] == ($past(polarity) ? `LCDSD_LEVEL_V3 : `LCDSD_LEVEL_V0))
        else $error("lit segment level wrong");

    display_on_c: cover property (cmd.display_on_command ##1 display_enabled);
    frame_wrap_c: cover property (af_tick && phase == 2'h3);
    write_read_c: cover property (cmd.ram_write ##1 cmd.ram_read ##1 rsp.valid);

endmodule

// ### lcdsd_glass.sv
// Behavioural model of the segment glass: records which dots see full drive
`timescale 1ns/1ps

module lcdsd_glass
    import lcdsd_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire lcdsd_level_type [3:0]  com_level,
    input  wire lcdsd_level_type [31:0] seg_level,
    output logic [31:0][3:0]            lit
);
    // ----------------------------------------------------------------
    // Dot state
    // ----------------------------------------------------------------
    // A dot is judged only while its common sits at an outer level; at the
    // inner levels every dot sees one bias step, too little to light it
    always_ff @(posedge core_clk) begin
        for (int k = 0; k < 32; k++) begin
            for (int n = 0; n < 4; n++) begin
                if (com_level[n] == 2'h0 || com_level[n] == 2'h3) begin
                    lit[k][n] <= (com_level[n] ^ seg_level[k]) == 2'h3;
                end
            end
        end
    end
endmodule

// ### tb_lcdsd_driver.sv
// Self-checking testbench of the segment LCD driver with a glass model
`timescale 1ns/1ps

module tb_lcdsd_driver
    import lcdsd_pkg::*;
;
    logic                   core_clk;
    logic                   sys_rst;
    logic                   slow_clk_pin;
    logic [1:0]             freq_select;
    lcdsd_cmd_type          cmd;
    lcdsd_rsp_type          rsp;
    lcdsd_level_type [3:0]  com_level;
    lcdsd_level_type [31:0] seg_level;
    logic                   display_enabled;
    logic [31:0][3:0]       lit;
    logic [31:0][3:0]       ram;
    int                     num_errors;
    int                     checked;
    int                     n;

    lcdsd_driver dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .slow_clk_pin(slow_clk_pin),
        .freq_select(freq_select), .cmd(cmd), .rsp(rsp), .com_level(com_level),
        .seg_level(seg_level), .display_enabled(display_enabled));
    lcdsd_glass glass_u (.core_clk(core_clk), .com_level(com_level), .seg_level(seg_level),
        .lit(lit));

    // ----------------------------------------------------------------
    // Clocks; slow clock sped up to 8 core cycles so frames stay short
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        slow_clk_pin = 1'b0;
        forever #20 slow_clk_pin = ~slow_clk_pin;
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Command kinds: 0 low, 1 high, 2 write, 3 read, 4 on, 5 off
    task automatic issue(input int k, input logic [3:0] d);
        lcdsd_cmd_type c;
        c = '0;
        c.data = d;
        case (k)
            0: c.pointer_low_load = 1'b1;
            1: c.pointer_high_load = 1'b1;
            2: c.ram_write = 1'b1;
            3: c.ram_read = 1'b1;
            4: c.display_on_command = 1'b1;
            default: c.display_off_command = 1'b1;
        endcase
        @(posedge core_clk);
        cmd <= c;
    endtask

    task automatic idle;
        @(posedge core_clk);
        cmd <= '0;
    endtask

    // Upper data bits of the high load set on purpose; they must be ignored
    task automatic point(input logic [5:0] a);
        issue(0, a[3:0]);
        issue(1, {2'h3, a[5:4]});
    endtask

    task automatic read_chk(input logic [5:0] a, input logic [3:0] e);
        point(a);
        issue(3, 4'h0);
        idle;
        #1;
        chk(rsp.valid, 1'b1);
        chk(rsp.data, e);
    endtask

    // Cycles until the commons change, bounded
    task automatic next_phase(output int cnt);
        lcdsd_level_type [3:0] p;
        p = com_level;
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1;
            cnt++;
        end while (com_level === p && cnt < 10000);
    endtask

    task automatic t_reset;
        chk(display_enabled, 1'b0);
        chk({com_level, seg_level}, '0);
    endtask

    task automatic t_ram;
        for (int k = 0; k < 32; k++) begin
            ram[k] = 4'(k * 5 + 3);
            point(6'(k));
            issue(2, ram[k]);
        end
        // Read right behind the last write must already see the new nibble
        issue(3, 4'h0);
        idle;
        #1;
        chk(rsp.valid, 1'b1);
        chk(rsp.data, ram[31]);
        point(6'h20);
        issue(2, 4'hF);
        idle;
        for (int k = 0; k < 32; k++) read_chk(6'(k), ram[k]);
        read_chk(6'h25, 4'h0);
    endtask

    task automatic t_display;
        issue(4, 4'h0);
        idle;
        #1;
        chk(display_enabled, 1'b1);
        for (int i = 0; i < 6; i++) next_phase(n);
        chk(lit, ram);
        for (int i = 0; i < 8 && com_level !== 8'h57; i++) next_phase(n);
        chk(com_level, 8'h57);
        for (int i = 0; i < 4; i++) next_phase(n);
        chk(com_level, 8'hA8);
    endtask

    task automatic t_divider;
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            freq_select <= 2'(s);
            next_phase(n);
            next_phase(n);
            chk(n, 512 << s);
        end
    endtask

    task automatic t_off;
        issue(5, 4'h0);
        idle;
        #1;
        chk(display_enabled, 1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        chk({com_level, seg_level}, '0);
    endtask

    // Reset while lit: drive drops, and stays off after release until turned on
    task automatic t_rerun;
        issue(4, 4'h0);
        repeat (2) idle;
        #1;
        chk(display_enabled, 1'b1);
        idle;
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        t_reset;
        @(posedge core_clk);
        #1;
        t_reset;
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        num_errors = 0;
        checked = 0;
        sys_rst = 1'b1;
        freq_select = 2'h0;
        cmd = '0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        t_reset;
        t_ram;
        t_display;
        t_divider;
        t_off;
        t_rerun;
        tally_and_finish;
    end
    initial begin
        #400000;
        num_errors++;
        tally_and_finish;
    end
endmodule
